//--- clock_startup_pkg.sv
// Package with constants, types and decode helpers for the clock source and start-up control block.
`default_nettype none
package clock_startup_pkg;

  // ==========================================================================
  // Register map (byte addresses on the 32-bit bus).
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_SLEEP_CMD = 4'h4;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;
  localparam logic [3:0] ADDR_FUSES     = 4'hC;

  // Control register fields and reset value.
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_ASYNC_BIT = 3;
  localparam int          CTRL_CONV_BIT  = 4;
  localparam logic [4:0]  CTRL_RESET     = 5'h00;
  localparam int          SLEEP_GO_BIT   = 0;

  // Status register field positions.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CLASS_LSB = 8;
  localparam int STAT_OSC_LSB   = 16;
  localparam int STAT_DLY_LSB   = 20;

  // ==========================================================================
  // Fuse encoding: one reads as unprogrammed, zero as programmed.
  // ==========================================================================
  localparam logic FUSE_UNPROGRAMMED = 1'b1;
  localparam logic FUSE_PROGRAMMED   = 1'b0;

  typedef struct packed {
    logic       oscillator_amp_option;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } fuse_set_t;

  // Fuse values as delivered: internal RC 1 MHz, slowly rising power.
  localparam fuse_set_t FUSE_DELIVERED = '{oscillator_amp_option: 1'b1,
                                           startup_time_fuses: 2'h2,
                                           clock_source_select_fuses: 4'h1};

  // Cycles of settling time for the fuse synchroniser before capture.
  localparam logic [1:0] FUSE_SETTLE_CYCLES = 2'h2;

  // ==========================================================================
  // Source classes, start-up counts and reset delays.
  // ==========================================================================
  typedef enum logic [2:0] {
    SRC_CRYSTAL  = 3'h0,
    SRC_LOW_FREQ = 3'h1,
    SRC_EXT_RC   = 3'h2,
    SRC_INT_RC   = 3'h3,
    SRC_EXT_CLK  = 3'h4
  } source_class_t;

  typedef enum logic [2:0] {
    OSC_6   = 3'h0,
    OSC_18  = 3'h1,
    OSC_258 = 3'h2,
    OSC_1K  = 3'h3,
    OSC_16K = 3'h4,
    OSC_32K = 3'h5
  } osc_count_t;

  typedef enum logic [1:0] {
    DLY_NONE = 2'h0,
    DLY_4K   = 2'h1,
    DLY_64K  = 2'h2
  } reset_delay_t;

  localparam int unsigned OSC_CYCLES_6   = 6;
  localparam int unsigned OSC_CYCLES_18  = 18;
  localparam int unsigned OSC_CYCLES_258 = 258;
  localparam int unsigned OSC_CYCLES_1K  = 1024;
  localparam int unsigned OSC_CYCLES_16K = 16384;
  localparam int unsigned OSC_CYCLES_32K = 32768;
  localparam int unsigned WDT_CYCLES_4K  = 4096;
  localparam int unsigned WDT_CYCLES_64K = 65536;
  localparam int          COUNT_W        = 17;

  // Sleep modes held in the control register.
  typedef enum logic [2:0] {
    SLP_IDLE       = 3'h0,
    SLP_CONV_QUIET = 3'h1,
    SLP_POWER_DOWN = 3'h2,
    SLP_POWER_SAVE = 3'h3,
    SLP_STANDBY    = 3'h6
  } sleep_mode_t;

  // Maps the four source select fuses to a source class.
  function automatic source_class_t source_class(input logic [3:0] sel);
    source_class_t c;
    c = SRC_EXT_CLK;
    if (sel >= 4'hA)
      c = SRC_CRYSTAL;
    else if (sel == 4'h9)
      c = SRC_LOW_FREQ;
    else if (sel >= 4'h5)
      c = SRC_EXT_RC;
    else if (sel >= 4'h1)
      c = SRC_INT_RC;
    return c;
  endfunction : source_class

  // Wake start-up count for the selected source and start-up fuses.
  function automatic osc_count_t osc_count(input fuse_set_t f);
    osc_count_t    o;
    logic [2:0]    key;
    key = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    o   = OSC_6;
    case (source_class(f.clock_source_select_fuses))
      SRC_CRYSTAL:  o = (key <= 3'h1) ? OSC_258 : ((key <= 3'h4) ? OSC_1K : OSC_16K);
      SRC_LOW_FREQ: o = (f.startup_time_fuses[1]) ? OSC_32K : OSC_1K;
      SRC_EXT_RC:   o = (f.startup_time_fuses == 2'h3) ? OSC_6 : OSC_18;
      default:      o = OSC_6;
    endcase
    return o;
  endfunction : osc_count

  // Extra reset delay, counted on the watchdog oscillator.
  function automatic reset_delay_t reset_delay(input fuse_set_t f);
    reset_delay_t d;
    logic [2:0]   key;
    key = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    d   = DLY_64K;
    case (source_class(f.clock_source_select_fuses))
      SRC_CRYSTAL:
        case (key)
          3'h2, 3'h5:       d = DLY_NONE;
          3'h0, 3'h3, 3'h6: d = DLY_4K;
          default:          d = DLY_64K;
        endcase
      SRC_LOW_FREQ: d = (f.startup_time_fuses == 2'h0) ? DLY_4K : DLY_64K;
      default:
        case (f.startup_time_fuses)
          2'h0:    d = DLY_NONE;
          2'h2:    d = DLY_64K;
          default: d = DLY_4K;
        endcase
    endcase
    return d;
  endfunction : reset_delay

endpackage : clock_startup_pkg
`default_nettype wire

//--- pin_sync.sv
// Two-stage synchroniser for inputs that arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int         W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,    // System clock.
  input  wire logic         rst_b,    // Asynchronous reset, active low.
  input  wire logic         clk_en,   // Freezes the stages while low.
  input  wire logic [W-1:0] async_in, // Unsynchronised inputs.
  output logic      [W-1:0] sync_out  // Synchronised inputs.
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_nxt;

  // ==========================================================================
  // Next values: the first stage feeds only the second.
  // ==========================================================================
  always_comb
  begin
    stage1_nxt = clk_en ? async_in : stage1_r;
    stage2_nxt = clk_en ? stage1_r : sync_out;
  end

  // Both stages reset to a constant.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_r <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      stage1_r <= stage1_nxt;
      sync_out <= stage2_nxt;
    end
  end

endmodule : pin_sync
`default_nettype wire

//--- clock_source_startup_control.sv
// Clock source decode, start-up timing and per-domain clock enables.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: The source select fuses decode to crystal, low-frequency crystal, external RC, internal RC or external clock.
// RULE2: A fuse reading one is unprogrammed and a fuse reading zero is programmed.
// RULE3: On wake from power-down or power-save the selected source's cycles are counted before execution resumes.
// RULE4: On start from reset a further delay of 4,096 or 65,536 watchdog oscillator cycles is inserted.
// RULE5: Fuses as delivered select the 1 MHz internal RC source with the slowly rising power start-up.
// RULE6: The asynchronous timer runs only while the core is clocked from the internal oscillator.
// RULE7: In crystal mode the upper three select bits and the amplifier option give the frequency range.
// RULE8: In crystal mode the low select bit and start-up fuses give a 258, 1K or 16K cycle wake count.
// RULE9: In crystal mode the low select bit and start-up fuses give no, 4.1 ms or 65 ms extra reset delay.
// RULE10: Each clock domain is gated on its own so sleep modes stop only the unused ones.
// RULE11: With the peripheral clock halted, two-wire address match and some external interrupts stay alive.
// RULE12: The program-memory clock is enabled and disabled together with the core clock.
// RULE13: The converter has its own domain that keeps running while core and peripheral clocks stop.
// RULE14: After reset the watchdog-timed delay runs first, then the oscillator count, then execution is released.
// RULE15: Fuses are captured once after reset and held so the source never changes while running.
module clock_source_startup_control #(
  parameter int unsigned OSC_16K_CYCLES = clock_startup_pkg::OSC_CYCLES_16K,
  parameter int unsigned OSC_32K_CYCLES = clock_startup_pkg::OSC_CYCLES_32K,
  parameter int unsigned WDT_64K_CYCLES = clock_startup_pkg::WDT_CYCLES_64K
) (
  input  wire logic        clock,                  // System clock, 125 MHz.
  input  wire logic        rst_b,                  // Asynchronous reset, active low.
  input  wire logic        clk_en,                 // Clock enable; low freezes all state.
  input  wire clock_startup_pkg::fuse_set_t fuses, // Fuse levels from the fuse array.
  input  wire logic        selected_osc_clock,     // Selected oscillator, sampled.
  input  wire logic        watchdog_osc_clock,     // Watchdog oscillator, sampled.
  input  wire logic        wake_event,             // Wake request from interrupt logic.
  input  wire logic [3:0]  avs_address,            // Avalon byte address.
  input  wire logic        avs_read,               // Avalon read request.
  input  wire logic        avs_write,              // Avalon write request.
  input  wire logic [31:0] avs_writedata,          // Avalon write data.
  output logic      [31:0] avs_readdata,           // Avalon read data.
  output logic             avs_waitrequest,        // Avalon wait request.
  output logic             exec_release,           // Instruction execution allowed.
  output logic             core_clock_en,          // Core clock domain enable.
  output logic             program_memory_clock_en,// Program-memory clock enable.
  output logic             peripheral_clock_en,    // Peripheral clock domain enable.
  output logic             async_timer_clock_en,   // Asynchronous timer clock enable.
  output logic             converter_clock_en,     // Converter clock domain enable.
  output logic             async_wake_detect_en,   // Async address match and interrupt detect.
  output logic             crystal_wide_range,     // Crystal amplifier in full-swing mode.
  output logic      [2:0]  crystal_range_select    // Crystal range code from fuses.
);

  // ==========================================================================
  // Types and signals.
  // ==========================================================================
  typedef enum logic [4:0] {
    ST_FUSE  = 5'b00001,
    ST_RDLY  = 5'b00010,
    ST_OSC   = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_SLEEP = 5'b10000
  } state_t;

  localparam int CW = clock_startup_pkg::COUNT_W;

  state_t                       state_r, state_nxt;
  clock_startup_pkg::fuse_set_t fuse_r, fuse_nxt;
  logic [1:0]                   settle_r, settle_nxt;
  logic [CW-1:0]                count_r, count_nxt;
  logic [4:0]                   ctrl_r, ctrl_nxt;
  logic                         osc_prev_r, wdt_prev_r;
  logic [9:0]                   sync_in, sync_out;
  logic                         osc_edge, wdt_edge, wake_s;
  clock_startup_pkg::fuse_set_t fuse_s;
  logic [CW-1:0]                osc_target, wdt_target;
  clock_startup_pkg::source_class_t src_class;
  clock_startup_pkg::sleep_mode_t   mode;
  logic                         int_rc;
  logic [31:0]                  rdata_nxt;
  logic                         wait_nxt, wr_take, sleep_go;
  logic                         core_nxt, periph_nxt, async_nxt, conv_nxt, rel_nxt;

  // ==========================================================================
  // Input synchronisers. Fuses reset to unprogrammed ones. [RULE2]
  // ==========================================================================
  assign sync_in = {wake_event, watchdog_osc_clock, selected_osc_clock, fuses};

  pin_sync #(
    .W       (10),
    .RST_VAL (10'h07F)
  ) u_pin_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  // Edge detection on the synchronised oscillator samples.
  // A source high at release gives one early edge.
  always_comb
  begin
    fuse_s   = clock_startup_pkg::fuse_set_t'(sync_out[6:0]);
    osc_edge = sync_out[7] & ~osc_prev_r;
    wdt_edge = sync_out[8] & ~wdt_prev_r;
    wake_s   = sync_out[9];
  end

  // ==========================================================================
  // Decode of the captured fuses.
  // ==========================================================================
  always_comb
  begin
    src_class = clock_startup_pkg::source_class(fuse_r.clock_source_select_fuses); // [RULE1]
    int_rc    = (src_class == clock_startup_pkg::SRC_INT_RC);
    mode      = clock_startup_pkg::sleep_mode_t'(ctrl_r[clock_startup_pkg::CTRL_MODE_LSB +: 3]);

    // Reserved codes fall back to the 6-cycle count.
    case (clock_startup_pkg::osc_count(fuse_r)) // [RULE8]
      clock_startup_pkg::OSC_18:  osc_target = CW'(clock_startup_pkg::OSC_CYCLES_18);
      clock_startup_pkg::OSC_258: osc_target = CW'(clock_startup_pkg::OSC_CYCLES_258);
      clock_startup_pkg::OSC_1K:  osc_target = CW'(clock_startup_pkg::OSC_CYCLES_1K);
      clock_startup_pkg::OSC_16K: osc_target = CW'(OSC_16K_CYCLES);
      clock_startup_pkg::OSC_32K: osc_target = CW'(OSC_32K_CYCLES);
      default:                    osc_target = CW'(clock_startup_pkg::OSC_CYCLES_6);
    endcase
    case (clock_startup_pkg::reset_delay(fuse_r)) // [RULE9]
      clock_startup_pkg::DLY_4K:  wdt_target = CW'(clock_startup_pkg::WDT_CYCLES_4K);
      clock_startup_pkg::DLY_64K: wdt_target = CW'(WDT_64K_CYCLES);
      default:                    wdt_target = '0;
    endcase
  end

  // ==========================================================================
  // Register bus: one wait cycle, then a one-cycle answer.
  // ==========================================================================
  always_comb
  begin
    // A write lands at the end of the answer cycle, one cycle after the wait ends.
    wait_nxt  = ~((avs_read | avs_write) & avs_waitrequest);
    wr_take   = avs_write & ~avs_waitrequest;
    sleep_go  = wr_take && (avs_address == clock_startup_pkg::ADDR_SLEEP_CMD)
                && avs_writedata[clock_startup_pkg::SLEEP_GO_BIT];
    ctrl_nxt  = ctrl_r;
    if (wr_take && (avs_address == clock_startup_pkg::ADDR_CTRL))
      ctrl_nxt = avs_writedata[4:0];

    // Read data stand until the next answer.
    rdata_nxt = avs_readdata;
    if (avs_read & avs_waitrequest)
    begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address)
        clock_startup_pkg::ADDR_CTRL:   rdata_nxt[4:0] = ctrl_r;
        clock_startup_pkg::ADDR_STATUS:
        begin
          rdata_nxt[clock_startup_pkg::STAT_STATE_LSB +: 5] = state_r;
          rdata_nxt[clock_startup_pkg::STAT_CLASS_LSB +: 3] = src_class;
          rdata_nxt[clock_startup_pkg::STAT_OSC_LSB +: 3]   = clock_startup_pkg::osc_count(fuse_r);
          rdata_nxt[clock_startup_pkg::STAT_DLY_LSB +: 2]   = clock_startup_pkg::reset_delay(fuse_r);
        end
        clock_startup_pkg::ADDR_FUSES:  rdata_nxt[6:0] = fuse_r;
        default:                        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Start-up sequencer next state.
  // ==========================================================================
  always_comb
  begin
    state_nxt  = state_r;
    fuse_nxt   = fuse_r;
    settle_nxt = settle_r;
    count_nxt  = count_r;
    case (state_r)
      ST_FUSE:
      begin
        // Wait for the synchroniser to fill.
        settle_nxt = settle_r + 2'h1;
        if (settle_r == clock_startup_pkg::FUSE_SETTLE_CYCLES)
        begin
          fuse_nxt  = fuse_s; // [RULE15]
          count_nxt = '0;
          state_nxt = ST_RDLY;
        end
      end
      ST_RDLY:
      begin
        // With >=, a zero target passes at once.
        if (count_r >= wdt_target) // [RULE4] [RULE14]
        begin
          count_nxt = '0;
          state_nxt = ST_OSC;
        end
        else if (wdt_edge)
          count_nxt = count_r + CW'(1);
      end
      ST_OSC:
      begin
        // Boot and wake share this count.
        if (count_r >= osc_target) // [RULE3] [RULE14]
        begin
          count_nxt = '0;
          state_nxt = ST_RUN;
        end
        else if (osc_edge)
          count_nxt = count_r + CW'(1);
      end
      ST_RUN:
      begin
        if (sleep_go)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        count_nxt = '0;
        if (wake_s)
        begin
          // Oscillator stopped only in the deep modes; those re-time start-up.
          if (mode == clock_startup_pkg::SLP_IDLE || mode == clock_startup_pkg::SLP_CONV_QUIET)
            state_nxt = ST_RUN;
          else
            state_nxt = ST_OSC; // [RULE3]
        end
      end
      default:
        state_nxt = ST_FUSE;
    endcase
  end

  // ==========================================================================
  // Per-domain enables derived from state and sleep mode.
  // ==========================================================================
  always_comb
  begin
    rel_nxt    = (state_r == ST_RUN);
    core_nxt   = rel_nxt; // [RULE10]
    periph_nxt = rel_nxt;
    conv_nxt   = rel_nxt & ctrl_r[clock_startup_pkg::CTRL_CONV_BIT];
    async_nxt  = rel_nxt;
    if (state_r == ST_SLEEP)
    begin
      periph_nxt = (mode == clock_startup_pkg::SLP_IDLE);
      conv_nxt   = ctrl_r[clock_startup_pkg::CTRL_CONV_BIT]
                   && (mode == clock_startup_pkg::SLP_IDLE
                       || mode == clock_startup_pkg::SLP_CONV_QUIET); // [RULE13]
      async_nxt  = (mode != clock_startup_pkg::SLP_POWER_DOWN) && (mode != clock_startup_pkg::SLP_STANDBY);
    end

    // The timer shares the oscillator pins.
    async_nxt = async_nxt & int_rc & ctrl_r[clock_startup_pkg::CTRL_ASYNC_BIT]; // [RULE6]
  end

  // ==========================================================================
  // State registers.
  // A low clk_en pauses the whole sequence.
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r                 <= ST_FUSE;
      fuse_r                  <= clock_startup_pkg::FUSE_DELIVERED; // [RULE5]
      settle_r                <= 2'h0;
      count_r                 <= '0;
      ctrl_r                  <= clock_startup_pkg::CTRL_RESET;
      osc_prev_r              <= 1'b0;
      wdt_prev_r              <= 1'b0;
      avs_readdata            <= 32'h0000_0000;
      avs_waitrequest         <= 1'b1;
      exec_release            <= 1'b0;
      core_clock_en           <= 1'b0;
      program_memory_clock_en <= 1'b0;
      peripheral_clock_en     <= 1'b0;
      async_timer_clock_en    <= 1'b0;
      converter_clock_en      <= 1'b0;
      async_wake_detect_en    <= 1'b1;
      crystal_wide_range      <= 1'b0;
      crystal_range_select    <= 3'h0;
    end
    else if (clk_en)
    begin
      state_r                 <= state_nxt;
      fuse_r                  <= fuse_nxt;
      settle_r                <= settle_nxt;
      count_r                 <= count_nxt;
      ctrl_r                  <= ctrl_nxt;
      osc_prev_r              <= sync_out[7];
      wdt_prev_r              <= sync_out[8];
      avs_readdata            <= rdata_nxt;
      avs_waitrequest         <= wait_nxt;
      exec_release            <= rel_nxt;
      core_clock_en           <= core_nxt;
      program_memory_clock_en <= core_nxt; // [RULE12]
      peripheral_clock_en     <= periph_nxt;
      async_timer_clock_en    <= async_nxt;
      converter_clock_en      <= conv_nxt;
      async_wake_detect_en    <= ~periph_nxt; // [RULE11]
      crystal_wide_range      <= (src_class == clock_startup_pkg::SRC_CRYSTAL)
                                 && (fuse_r.oscillator_amp_option == clock_startup_pkg::FUSE_PROGRAMMED); // [RULE7]
      crystal_range_select    <= fuse_r.clock_source_select_fuses[3:1]; // [RULE7]
    end
  end

endmodule : clock_source_startup_control
`default_nettype wire

//--- clock_startup_asserts.sv
// Port-level assertions for the clock start-up control block.
`timescale 1ns/1ps
`default_nettype none
module clock_startup_asserts (
  input wire logic clock, // Clock.
  input wire logic rst_b, // Reset.
  input wire logic clk_en, // Enable.
  input wire clock_startup_pkg::fuse_set_t fuses, // Fuses.
  input wire logic avs_read, // Read.
  input wire logic avs_write, // Write.
  input wire logic avs_waitrequest, // Wait.
  input wire logic exec_release, // Run.
  input wire logic core_clock_en, // Core.
  input wire logic program_memory_clock_en, // Memory.
  input wire logic peripheral_clock_en, // Peripheral.
  input wire logic async_timer_clock_en, // Timer.
  input wire logic async_wake_detect_en, // Detect.
  input wire logic crystal_wide_range, // Swing.
  input wire logic [2:0] crystal_range_select // Range.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========
  // Domain gating, timer source, crystal range and boot hold checks.
  property p_pm_core; program_memory_clock_en == core_clock_en; endproperty
  a_pm_core: assert property (p_pm_core) else $error("memory gate differs");
  property p_wake_det; async_wake_detect_en == !peripheral_clock_en; endproperty
  a_wake_det: assert property (p_wake_det) else $error("detect wrong");
  property p_sleep_off; $fell(exec_release) |-> ##[0:2] !core_clock_en; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("core still on");
  property p_async_rc;
    async_timer_clock_en |-> fuses.clock_source_select_fuses inside {[4'h1:4'h4]};
  endproperty
  a_async_rc: assert property (p_async_rc) else $error("timer off RC");
  property p_xtal;
    exec_release && fuses.clock_source_select_fuses >= 4'hA |->
      crystal_range_select == fuses.clock_source_select_fuses[3:1]
      && crystal_wide_range == !fuses.oscillator_amp_option;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal range wrong");
  property p_boot_hold; $rose(rst_b) |-> !exec_release [*8]; endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("early run");
  // ==========
  // Bus answers after exactly one wait cycle and for one cycle only.
  property p_wait_one;
    clk_en && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("late answer");
  property p_wait_pulse; clk_en && !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("long answer");
endmodule : clock_startup_asserts
bind clock_source_startup_control clock_startup_asserts u_chk (.clock, .rst_b, .clk_en,
  .fuses, .avs_read, .avs_write, .avs_waitrequest, .exec_release, .core_clock_en,
  .program_memory_clock_en, .peripheral_clock_en, .async_timer_clock_en,
  .async_wake_detect_en, .crystal_wide_range, .crystal_range_select);
`default_nettype wire

//--- clock_source_startup_control_tb_top.sv
// Self-checking bench for the clock source and start-up control block.
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_control_tb_top;
  logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, wake_event = 1'b0;
  logic selected_osc_clock = 1'b0, watchdog_osc_clock = 1'b0, wd_run = 1'b0, osc_run = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, exec_release;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic core_clock_en, program_memory_clock_en, peripheral_clock_en, async_timer_clock_en;
  logic converter_clock_en, async_wake_detect_en, crystal_wide_range;
  logic [2:0] crystal_range_select;
  logic [1:0] ph = 2'h0;
  clock_startup_pkg::fuse_set_t fuses = '1;
  int n_errors = 0, num_checks = 0, cyc = 0;
  clock_source_startup_control #(.OSC_16K_CYCLES(16), .OSC_32K_CYCLES(32),
    .WDT_64K_CYCLES(64)) u_clock_source_startup_control (.*);
  always #4 clock = ~clock;
  // Oscillator stand-ins: two clocks high, two low, frozen while disabled.
  always @(posedge clock)
  begin
    ph <= ph + 2'h1;
    if (wd_run) watchdog_osc_clock <= ph[1];
    if (osc_run) selected_osc_clock <= ph[1];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========
  // Reporting, comparison and bus tasks.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Status word from state, source class, start-up code and delay code.
  function automatic logic [31:0] st(input logic [4:0] s, input logic [2:0] c, input logic [2:0] o,
                                     input logic [1:0] dl);
    return {10'h000, dl, 1'b0, o, 5'h00, c, 3'h0, s};
  endfunction : st
  // Resets with new fuses, oscillators stopped, and checks the status.
  task automatic boot(input logic [6:0] f, input logic [31:0] e);
    rst_b <= 1'b0;
    fuses <= clock_startup_pkg::fuse_set_t'(f);
    wd_run <= 1'b0;
    osc_run <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    rd(clock_startup_pkg::ADDR_STATUS, e);
  endtask : boot
  task automatic wait_exec();
    repeat (400)
      if (exec_release !== 1'b1) @(posedge clock);
    chk({31'h0, exec_release}, 32'h1);
  endtask : wait_exec
  // Sleeps in a mode, checks gates, wakes with the oscillator held.
  task automatic sleep_wake(input logic [4:0] c, input logic [2:0] e);
    wr(clock_startup_pkg::ADDR_CTRL, {27'h0, c});
    rd(clock_startup_pkg::ADDR_CTRL, {27'h0, c});
    wr(clock_startup_pkg::ADDR_SLEEP_CMD, 32'h1);
    repeat (4) @(posedge clock);
    chk({29'h0, core_clock_en, peripheral_clock_en,
         c[1:0] == 2'h3 ? async_timer_clock_en : converter_clock_en}, {29'h0, e});
    osc_run <= 1'b0;
    wake_event <= 1'b1;
    repeat (30) @(posedge clock);
    wake_event <= 1'b0;
    chk({31'h0, exec_release}, {31'h0, c[1] == 1'b0});
    osc_run <= 1'b1;
    wait_exec();
  endtask : sleep_wake
  // ==========
  // Scenarios.
  task automatic t_classes();
    boot(7'h40, st(5'h04, 3'h4, 3'h0, 2'h0));
    boot(7'h45, st(5'h04, 3'h2, 3'h1, 2'h0));
    boot(7'h49, st(5'h02, 3'h1, 3'h3, 2'h1));
    boot(7'h4A, st(5'h02, 3'h0, 3'h2, 2'h1));
    $display("Test classes done");
  endtask : t_classes
  task automatic t_delivered();
    boot(7'h61, st(5'h02, 3'h3, 3'h0, 2'h2));
    clk_en <= 1'b0;
    wd_run <= 1'b1;
    repeat (400) @(posedge clock);
    clk_en <= 1'b1;
    rd(clock_startup_pkg::ADDR_STATUS, st(5'h02, 3'h3, 3'h0, 2'h2));
    repeat (400) @(posedge clock);
    rd(clock_startup_pkg::ADDR_STATUS, st(5'h04, 3'h3, 3'h0, 2'h2));
    chk({31'h0, exec_release}, 32'h0);
    osc_run <= 1'b1;
    wait_exec();
    wr(clock_startup_pkg::ADDR_FUSES, 32'h0);
    rd(clock_startup_pkg::ADDR_FUSES, 32'h61);
    rd(4'h2, 32'h0);
    sleep_wake(5'h00, 3'h2);
    sleep_wake(5'h11, 3'h1);
    sleep_wake(5'h0B, 3'h1);
    sleep_wake(5'h02, 3'h0);
    sleep_wake(5'h06, 3'h0);
    $display("Test delivered done");
  endtask : t_delivered
  task automatic t_crystal();
    boot(7'h1F, st(5'h04, 3'h0, 3'h4, 2'h0));
    osc_run <= 1'b1;
    wait_exec();
    chk({28'h0, crystal_wide_range, crystal_range_select}, 32'hF);
    sleep_wake(5'h0B, 3'h0);
    $display("Test crystal done");
  endtask : t_crystal
  initial
  begin
    t_classes();
    t_delivered();
    t_crystal();
    give_verdict();
  end
endmodule : clock_source_startup_control_tb_top
`default_nettype wire
